// >>> rtl/crtc_buf.sv
// two-entry buffer between the host strobe capture and the command engine
// assumes DEPTH is a power of two
`timescale 1ns/100ps
module crtc_buf #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != (PW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + PW'(push);
      rd_ptr_reg <= rd_ptr_reg + PW'(pop);
      count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

// >>> rtl/crtc_pkg.sv
// constants shared by the text display controller and its helpers
// assumes a single 250 MHz system clock and synchronous active-high reset
//
// Contract
// RULE_01: all timing from dot tick, seven-phase ring
// RULE_02: printable: latch at sync start, write at load
// RULE_03: character writes only inside horizontal sync
// RULE_04: 256 lines, vertical blank lines 240..255
// RULE_05: vertical sync lines 240..242, three sweeps
// RULE_06: 80 char times, blank after 64th
// RULE_07: blank hides video, blank onset steps line
// RULE_08: horizontal sync char times 69..72
// RULE_09: blank ends after char time 80
// RULE_10: display char counter cleared times 65..78
// RULE_11: home: char zero, row from roll counter
// RULE_12: return: char zero, row kept
// RULE_13: up: cursor row minus one
// RULE_14: down/feed: row plus one, roll at bottom
// RULE_15: left: char minus one, wraps same row
// RULE_16: right: char plus one
// RULE_17: bell: timed alarm pulse every 16 fields
// RULE_18: erase: clear roll, rows at blank, fill
// RULE_19: erase fills every load, row steps, ends
// RULE_20: roll: busy, char zero, fill, roll plus one
// RULE_21: roll fills 64 spaces, then display addressing
// RULE_22: after roll display row steps at sync
// RULE_23: fifteen lines per row, then step pulse
// RULE_24: ready low only while selected and idle
// RULE_25: fill character is ascii space
package crtc_pkg;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int DOT_PERIOD_PS = 116000;
  localparam int DOT_CYC = DOT_PERIOD_PS / CLK_PERIOD_PS;
  localparam int RING_LEN = 7;
  localparam int RING_LOAD = 3;
  localparam logic [6:0] HCNT_LAST = 7'h4f;
  localparam logic [6:0] HB_FIRST = 7'h40;
  localparam logic [6:0] HS_FIRST = 7'h44;
  localparam logic [6:0] HS_LAST = 7'h47;
  localparam logic [6:0] DRST_FIRST = 7'h40;
  localparam logic [6:0] DRST_LAST = 7'h4d;
  localparam logic [7:0] VB_FIRST = 8'hf0;
  localparam logic [7:0] VS_LAST = 8'hf2;
  localparam logic [3:0] ROW_LINE_LAST = 4'he;
  localparam logic [3:0] CURSOR_LINE = 4'h9;
  localparam logic [5:0] COL_LAST = 6'h3f;
  localparam logic [3:0] ROW_LAST = 4'hf;
  localparam int ALARM_FIELDS = 64;
  localparam logic [7:0] PRINT_MIN = 8'h20;
  localparam logic [7:0] SPACE_CODE = 8'h20;
  localparam logic [7:0] CODE_HOME = 8'h01;
  localparam logic [7:0] CODE_ERASE = 8'h03;
  localparam logic [7:0] CODE_BELL = 8'h07;
  localparam logic [7:0] CODE_LEFT = 8'h08;
  localparam logic [7:0] CODE_RIGHT = 8'h09;
  localparam logic [7:0] CODE_DOWN = 8'h0a;
  localparam logic [7:0] CODE_UP = 8'h0c;
  localparam logic [7:0] CODE_RETURN = 8'h0d;
endpackage

// >>> rtl/crtc_tim_if.sv
// timing strobes and levels from the raster generator to the controller
// all signals are on clk_sys; strobes last one cycle
`timescale 1ns/100ps
interface crtc_tim_if;
  logic char_start;
  logic shift_load;
  logic hb_onset;
  logic hs_rise;
  logic step_row;
  logic field_pulse;
  logic hb;
  logic hs;
  logic vb;
  logic vs;
  logic dchar_rst;
  logic [3:0] row_line;
  modport src (output char_start, shift_load, hb_onset, hs_rise, step_row, field_pulse,
    hb, hs, vb, vs, dchar_rst, row_line);
  modport dst (input char_start, shift_load, hb_onset, hs_rise, step_row, field_pulse,
    hb, hs, vb, vs, dchar_rst, row_line);
endinterface

// >>> rtl/crtc_timing.sv
// raster generator: dot tick, character ring, character, line and row-line counters
// assumes clk_sys at 250 MHz so the dot tick is an integer divide
`timescale 1ns/100ps
module crtc_timing
  import crtc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  crtc_tim_if.src tim
);
  logic [4:0] dot_cnt_reg;
  logic [RING_LEN-1:0] ring_reg;
  logic [6:0] hcnt_reg;
  logic [7:0] line_reg;
  logic [3:0] row_line_reg;
  logic dot_tick;
  logic char_end;

  assign dot_tick = (dot_cnt_reg == 5'(DOT_CYC - 1));
  assign char_end = dot_tick & ring_reg[RING_LEN-1];
  assign tim.char_start = dot_tick & ring_reg[0]; // RULE_01
  assign tim.shift_load = dot_tick & ring_reg[RING_LOAD];
  assign tim.hb = (hcnt_reg >= HB_FIRST); // RULE_06 RULE_09
  assign tim.hs = (hcnt_reg >= HS_FIRST) && (hcnt_reg <= HS_LAST); // RULE_08
  assign tim.dchar_rst = (hcnt_reg >= DRST_FIRST) && (hcnt_reg <= DRST_LAST); // RULE_10
  assign tim.vb = (line_reg >= VB_FIRST); // RULE_04
  assign tim.vs = (line_reg >= VB_FIRST) && (line_reg <= VS_LAST); // RULE_05
  assign tim.hb_onset = char_end && (hcnt_reg == HB_FIRST - 7'h01);
  assign tim.hs_rise = char_end && (hcnt_reg == HS_FIRST - 7'h01);
  assign tim.step_row = tim.hb_onset && !tim.vb && (row_line_reg == ROW_LINE_LAST); // RULE_23
  assign tim.field_pulse = tim.hb_onset && (line_reg == 8'hff);
  assign tim.row_line = row_line_reg;

  // ring and dot divider
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dot_cnt_reg <= '0;
      ring_reg <= {{(RING_LEN-1){1'b0}}, 1'b1};
    end else begin
      dot_cnt_reg <= dot_tick ? 5'h00 : dot_cnt_reg + 5'h01;
      if (dot_tick) begin
        ring_reg <= {ring_reg[RING_LEN-2:0], ring_reg[RING_LEN-1]}; // RULE_01
      end
    end
  end

  // character, line and row-line counters
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      hcnt_reg <= '0;
      line_reg <= '0;
      row_line_reg <= '0;
    end else begin
      if (char_end) begin
        hcnt_reg <= (hcnt_reg == HCNT_LAST) ? 7'h00 : hcnt_reg + 7'h01; // RULE_06
      end
      if (tim.hb_onset) begin
        line_reg <= line_reg + 8'h01; // RULE_07 RULE_04
        if (tim.vb || row_line_reg == ROW_LINE_LAST) begin
          row_line_reg <= 4'h0; // RULE_23
        end else begin
          row_line_reg <= row_line_reg + 4'h1;
        end
      end
    end
  end
endmodule

// >>> rtl/crtc_top.sv
// character-cell text display controller: host byte intake, command engine,
// display memory, cursor, roll, erase, bell and video output
// assumes host pins are asynchronous to clk_sys and are synchronised here
`timescale 1ns/100ps
module crtc_top
  import crtc_pkg::*;
#(
  parameter int ALARM_LEN = ALARM_FIELDS
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic dev_select,
  input wire logic [7:0] output_bus,
  input wire logic output_bus_strobe_n,
  output logic ready_n,
  output logic write_enable,
  output logic space_force_enable,
  output logic horiz_blank,
  output logic horiz_sync,
  output logic vert_blank,
  output logic vert_sync,
  output logic video_on,
  output logic [7:0] video_char,
  output logic cursor_on,
  output logic alarm_pulse
);
  // ************************************************************
  // declarations
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WRITE = 3'b001,
    ST_ERASE_VB = 3'b010,
    ST_ARM = 3'b011,
    ST_FILL = 3'b100
  } crtc_state_e;

  crtc_tim_if tim ();

  crtc_state_e state_reg;
  logic sel_s1_reg;
  logic sel_s2_reg;
  logic obs_s1_reg;
  logic obs_s2_reg;
  logic obs_s3_reg;
  logic [7:0] ob_s1_reg;
  logic [7:0] ob_s2_reg;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_out_ready;
  logic [7:0] buf_out_data;
  logic push;
  logic take;
  logic [7:0] char_reg;
  logic wq0_reg;
  logic fill_erase_reg;
  logic [5:0] cchar_reg;
  logic [3:0] crow_reg;
  logic [3:0] roll_reg;
  logic [3:0] crow_up;
  logic roll_step_reg;
  logic bell_reg;
  logic [5:0] dchar_reg;
  logic [3:0] drow_reg;
  logic [7:0] ram_reg [1024];
  logic [9:0] wr_addr;
  logic [7:0] wr_data;
  logic wr_now;
  logic write_enable_reg;
  logic [7:0] video_char_reg;
  logic video_on_reg;
  logic cursor_on_reg;
  logic [$clog2(ALARM_LEN+1)-1:0] alarm_timer_reg;
  logic [3:0] field_cnt_reg;
  logic alarm_pulse_reg;

  // ************************************************************
  // raster timing
  // ************************************************************
  crtc_timing u_timing (
    .clk_sys(clk_sys),
    .srst(srst),
    .tim(tim.src)
  );

  assign horiz_blank = tim.hb;
  assign horiz_sync = tim.hs;
  assign vert_blank = tim.vb;
  assign vert_sync = tim.vs;

  // ************************************************************
  // host intake
  // ************************************************************
  // bus data must be stable before the strobe falls; it passes the same
  // two stages so the captured word lines up with the detected edge
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sel_s1_reg <= 1'b0;
      sel_s2_reg <= 1'b0;
      obs_s1_reg <= 1'b1;
      obs_s2_reg <= 1'b1;
      obs_s3_reg <= 1'b1;
      ob_s1_reg <= 8'h00;
      ob_s2_reg <= 8'h00;
    end else begin
      sel_s1_reg <= dev_select;
      sel_s2_reg <= sel_s1_reg;
      obs_s1_reg <= output_bus_strobe_n;
      obs_s2_reg <= obs_s1_reg;
      obs_s3_reg <= obs_s2_reg;
      ob_s1_reg <= output_bus;
      ob_s2_reg <= ob_s1_reg;
    end
  end

  assign push = obs_s3_reg & ~obs_s2_reg & sel_s2_reg;

  crtc_buf #(
    .W(8),
    .DEPTH(2)
  ) u_buf (
    .clk_sys(clk_sys),
    .srst(srst),
    .in_valid(push),
    .in_ready(buf_in_ready),
    .in_data(ob_s2_reg),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out_data)
  );

  // busy covers queued words as well as a running operation
  assign ready_n = ~(sel_s2_reg & (state_reg == ST_IDLE) & ~buf_out_valid
    & buf_in_ready); // RULE_24 RULE_20

  assign buf_out_ready = (state_reg == ST_IDLE);
  assign take = buf_out_valid & buf_out_ready;
  assign crow_up = crow_reg + 4'h1;

  // ************************************************************
  // command engine, cursor and roll counters
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      char_reg <= 8'h00;
      wq0_reg <= 1'b0;
      fill_erase_reg <= 1'b0;
      cchar_reg <= 6'h00;
      crow_reg <= 4'h0;
      roll_reg <= 4'h0;
      roll_step_reg <= 1'b0;
      bell_reg <= 1'b0;
    end else begin
      bell_reg <= 1'b0;
      if (tim.hs_rise) begin
        roll_step_reg <= 1'b0;
      end
      case (state_reg)
        ST_IDLE: begin
          if (take) begin
            if (buf_out_data >= PRINT_MIN) begin
              char_reg <= buf_out_data;
              state_reg <= ST_WRITE;
            end else begin
              case (buf_out_data)
                CODE_HOME: begin
                  cchar_reg <= 6'h00; // RULE_11
                  crow_reg <= roll_reg; // RULE_11
                end
                CODE_RETURN: begin
                  cchar_reg <= 6'h00; // RULE_12
                end
                CODE_UP: begin
                  crow_reg <= crow_reg - 4'h1; // RULE_13
                end
                CODE_DOWN: begin
                  crow_reg <= crow_up; // RULE_14
                  if (crow_up == roll_reg) begin
                    // the new bottom line is the old top line: clear it
                    cchar_reg <= 6'h00; // RULE_20
                    roll_reg <= roll_reg + 4'h1; // RULE_20
                    fill_erase_reg <= 1'b0;
                    state_reg <= ST_ARM; // RULE_14
                  end
                end
                CODE_LEFT: begin
                  cchar_reg <= cchar_reg - 6'h01; // RULE_15
                end
                CODE_RIGHT: begin
                  cchar_reg <= cchar_reg + 6'h01; // RULE_16
                end
                CODE_BELL: begin
                  bell_reg <= 1'b1; // RULE_17
                end
                CODE_ERASE: begin
                  roll_reg <= 4'h0; // RULE_18
                  fill_erase_reg <= 1'b1;
                  state_reg <= ST_ERASE_VB;
                end
                default: begin
                end
              endcase
            end
          end
        end
        ST_WRITE: begin
          // one character per character time: each latch waits for sync
          if (!wq0_reg && tim.hs && tim.char_start) begin
            wq0_reg <= 1'b1; // RULE_02 RULE_03
          end else if (wq0_reg && tim.shift_load) begin
            wq0_reg <= 1'b0; // RULE_02
            cchar_reg <= cchar_reg + 6'h01;
            state_reg <= ST_IDLE;
          end
        end
        ST_ERASE_VB: begin
          if (tim.vb) begin
            crow_reg <= roll_reg; // RULE_18
            cchar_reg <= 6'h00;
            state_reg <= ST_ARM;
          end
        end
        ST_ARM: begin
          if (tim.char_start) begin
            state_reg <= ST_FILL; // RULE_18
          end
        end
        ST_FILL: begin
          if (tim.shift_load) begin
            cchar_reg <= cchar_reg + 6'h01; // RULE_19 RULE_21
            if (cchar_reg == COL_LAST) begin
              if (!fill_erase_reg) begin
                roll_step_reg <= 1'b1; // RULE_22
                state_reg <= ST_IDLE; // RULE_21
              end else if (crow_reg == ROW_LAST) begin
                crow_reg <= 4'h0; // RULE_19
                state_reg <= ST_IDLE;
              end else begin
                crow_reg <= crow_up; // RULE_19
              end
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  assign space_force_enable = (state_reg == ST_FILL);

  // ************************************************************
  // display memory
  // ************************************************************
  assign wr_now = tim.shift_load
    & (((state_reg == ST_WRITE) & wq0_reg) | (state_reg == ST_FILL)); // RULE_02 RULE_21
  assign wr_addr = {crow_reg, cchar_reg};
  assign wr_data = (state_reg == ST_FILL) ? SPACE_CODE : char_reg; // RULE_25

  always_ff @(posedge clk_sys) begin
    if (wr_now) begin
      ram_reg[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      write_enable_reg <= 1'b0;
    end else begin
      write_enable_reg <= wr_now;
    end
  end

  assign write_enable = write_enable_reg;

  // ************************************************************
  // display addressing
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dchar_reg <= 6'h00;
    end else if (tim.dchar_rst) begin
      dchar_reg <= 6'h00; // RULE_10
    end else if (tim.char_start && !tim.hb) begin
      dchar_reg <= dchar_reg + 6'h01;
    end
  end

  // top row follows the roll count each field; a finished roll also
  // steps it early so the moved picture shows on the next line
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      drow_reg <= 4'h0;
    end else if (state_reg == ST_ERASE_VB && tim.vb) begin
      drow_reg <= 4'h0; // RULE_18
    end else if (tim.field_pulse) begin
      drow_reg <= roll_reg;
    end else if (tim.step_row || (roll_step_reg && tim.hs_rise)) begin
      drow_reg <= drow_reg + 4'h1; // RULE_23 RULE_22
    end
  end

  // ************************************************************
  // video output
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      video_char_reg <= 8'h00;
      video_on_reg <= 1'b0;
      cursor_on_reg <= 1'b0;
    end else if (tim.char_start) begin
      video_on_reg <= !tim.hb && !tim.vb; // RULE_07
      video_char_reg <= (!tim.hb && !tim.vb) ? ram_reg[{drow_reg, dchar_reg}] : 8'h00; // RULE_07
      cursor_on_reg <= !tim.hb && !tim.vb && (tim.row_line == CURSOR_LINE)
        && (drow_reg == crow_reg) && (dchar_reg == cchar_reg);
    end
  end

  assign video_char = video_char_reg;
  assign video_on = video_on_reg;
  assign cursor_on = cursor_on_reg;

  // ************************************************************
  // audible alarm
  // ************************************************************
  // a bell during a running alarm restarts the timer rather than queueing
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      alarm_timer_reg <= '0;
      field_cnt_reg <= 4'h0;
      alarm_pulse_reg <= 1'b0;
    end else begin
      alarm_pulse_reg <= 1'b0;
      if (bell_reg) begin
        alarm_timer_reg <= ($clog2(ALARM_LEN+1))'(ALARM_LEN); // RULE_17
      end else if (tim.field_pulse && alarm_timer_reg != '0) begin
        alarm_timer_reg <= alarm_timer_reg - 1'b1;
      end
      if (tim.field_pulse) begin
        field_cnt_reg <= field_cnt_reg + 4'h1;
        alarm_pulse_reg <= (alarm_timer_reg != '0) && (field_cnt_reg == 4'h0); // RULE_17
      end
    end
  end

  assign alarm_pulse = alarm_pulse_reg;
endmodule

// >>> verif/crt_text_display_controller_bench.sv
// self-checking bench for crtc_top with the host model on its bus
// assumes a 4 ns clk_sys; the raster runs at full length, so only lines are seen
`timescale 1ns/100ps
module crt_text_display_controller_bench;
  import crtc_pkg::*;
  localparam int RUN_LIMIT = 6 * 80 * RING_LEN * DOT_CYC;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic dev_select;
  logic [7:0] output_bus;
  logic output_bus_strobe_n;
  logic ready_n;
  logic write_enable;
  logic space_force_enable;
  int fail_count = 0;
  int checks = 0;
  int we_count = 0;
  logic fill_seen = 1'b0;
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (write_enable === 1'b1) we_count <= we_count + 1;
    if (space_force_enable === 1'b1) fill_seen <= 1'b1;
  end
  crtc_top #(.ALARM_LEN(2)) u_crtc_top (
    .clk_sys(clk_sys), .srst(srst), .dev_select(dev_select), .output_bus(output_bus),
    .output_bus_strobe_n(output_bus_strobe_n), .ready_n(ready_n),
    .write_enable(write_enable), .space_force_enable(space_force_enable),
    .horiz_blank(), .horiz_sync(), .vert_blank(), .vert_sync(), .video_on(),
    .video_char(), .cursor_on(), .alarm_pulse()
  );
  crtc_host_model u_crtc_host_model (
    .clk_sys(clk_sys), .ready_n(ready_n), .dev_select(dev_select),
    .output_bus(output_bus), .output_bus_strobe_n(output_bus_strobe_n)
  );
  // ****************************************
  // checking and verdict
  // ****************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  function automatic int writes_for(input logic [7:0] code);
    return (code >= PRINT_MIN) ? 1 : 0;
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // send one byte and compare the write pulses it caused
  task automatic run_code(input logic [7:0] code, input int exp_we);
    int base;
    bit ok;
    base = we_count;
    u_crtc_host_model.send(code, $urandom_range(5), ok);
    repeat (4) @(posedge clk_sys);
    check("host handshake", ok, 1);
    check("write pulses", we_count - base, exp_we);
  endtask
  initial begin
    logic [7:0] seq [8];
    int base;
    void'($urandom(11590));
    seq = '{PRINT_MIN, CODE_HOME, CODE_RETURN, 8'h00, CODE_RIGHT, CODE_LEFT, CODE_BELL, 8'h1f};
    seq[3] = 8'($urandom_range(255, 32));
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (6) @(posedge clk_sys);
    check("ready_n deselected", ready_n, 1);
    base = we_count;
    u_crtc_host_model.pulse(8'h41);
    u_crtc_host_model.select(1'b1);
    repeat (8) @(posedge clk_sys);
    check("ready_n selected idle", ready_n, 0);
    check("ignored strobe", we_count - base, 0);
    $display("test deselect done");
    for (int i = 0; i < 8; i++) begin
      run_code(seq[i], writes_for(seq[i]));
    end
    check("no fill yet", fill_seen, 0);
    $display("test codes done");
    // up from row 0 lands on row 15, so the feed wraps onto the roll row
    run_code(CODE_UP, 0);
    run_code(CODE_DOWN, 64);
    check("fill seen", fill_seen, 1);
    // roll count is now 1: a feed from row 15 to row 0 must not roll
    run_code(CODE_UP, 0);
    run_code(CODE_DOWN, 0);
    $display("test roll done");
    conclude();
  end
  // limit reckoned as a few full lines beyond the expected run
  initial begin
    repeat (RUN_LIMIT) @(posedge clk_sys);
    fail_count++;
    conclude();
  end
endmodule

// >>> verif/crtc_host_model.sv
// host side model: selects the controller and strobes bytes onto the bus
// assumes the bench calls its tasks; drives change just after clk_sys rises
`timescale 1ns/100ps
module crtc_host_model (
  input wire logic clk_sys,
  input wire logic ready_n,
  output logic dev_select,
  output logic [7:0] output_bus,
  output logic output_bus_strobe_n
);
  initial begin
    dev_select = 1'b0;
    output_bus = 8'h00;
    output_bus_strobe_n = 1'b1;
  end
  task automatic select(input logic sel);
    @(posedge clk_sys);
    dev_select <= sel;
  endtask
  // blind strobe, used only where no answer is expected
  task automatic pulse(input logic [7:0] code);
    @(posedge clk_sys);
    output_bus <= code;
    output_bus_strobe_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    output_bus_strobe_n <= 1'b1;
    output_bus <= ~code;
  endtask
  // gap makes the host slow; the released bus shows the inverse, never stale data
  task automatic send(input logic [7:0] code, input int gap, output bit ok);
    int n;
    n = 0;
    while (ready_n !== 1'b0 && n < 40000) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (gap) @(posedge clk_sys);
    output_bus <= code;
    output_bus_strobe_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    n = 0;
    while (ready_n !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    output_bus_strobe_n <= 1'b1;
    output_bus <= ~code;
    repeat (3) @(posedge clk_sys);
    n = 0;
    while (ready_n !== 1'b0 && n < 40000) begin
      @(posedge clk_sys);
      n++;
    end
    ok = (ready_n === 1'b0);
  endtask
endmodule

// >>> verif/crtc_top_assertions.sv
// concurrent checks on the display controller's top-level ports
// assumes one clk_sys domain and the synchronous active-high srst
`timescale 1ns/100ps
module crtc_top_checker
  import crtc_pkg::*;
#(
  parameter int ALARM_LEN = ALARM_FIELDS
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic dev_select,
  input wire logic [7:0] output_bus,
  input wire logic output_bus_strobe_n,
  input wire logic ready_n,
  input wire logic write_enable,
  input wire logic space_force_enable,
  input wire logic horiz_blank,
  input wire logic horiz_sync,
  input wire logic vert_blank,
  input wire logic vert_sync,
  input wire logic video_on,
  input wire logic [7:0] video_char,
  input wire logic cursor_on,
  input wire logic alarm_pulse
);
  localparam int CHAR_CLK = DOT_CYC * RING_LEN;
  int hs_cnt_reg;
  int hb_cnt_reg;
  int line_cnt_reg;
  logic hb_q_reg;
  logic seen_reg;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // ****************************************
  // raster counters
  // ****************************************
  always_ff @(posedge clk_sys) begin
    hs_cnt_reg <= (srst || !horiz_sync) ? 0 : hs_cnt_reg + 1;
  end
  always_ff @(posedge clk_sys) begin
    hb_cnt_reg <= (srst || !horiz_blank) ? 0 : hb_cnt_reg + 1;
  end
  // the first line after reset is counted from reset, not from a blank onset, so it is skipped
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      line_cnt_reg <= 0;
      hb_q_reg <= 1'b0;
      seen_reg <= 1'b0;
    end else begin
      hb_q_reg <= horiz_blank;
      line_cnt_reg <= (horiz_blank && !hb_q_reg) ? 1 : line_cnt_reg + 1;
      seen_reg <= seen_reg | (horiz_blank & ~hb_q_reg);
    end
  end
  property p_hs_in_hb;
    horiz_sync |-> horiz_blank;
  endproperty
  a_hs_in_hb: assert property (p_hs_in_hb)
    else $error("hsync outside hblank");
  // fill writes run on every load pulse; only host characters wait for sync
  property p_we_in_hs;
    write_enable && !$past(space_force_enable) |-> horiz_sync;
  endproperty
  a_we_in_hs: assert property (p_we_in_hs)
    else $error("write outside hsync");
  property p_video_off;
    horiz_sync |-> !video_on && video_char == 8'h00;
  endproperty
  a_video_off: assert property (p_video_off)
    else $error("video during blanking");
  property p_hs_width;
    $fell(horiz_sync) |-> hs_cnt_reg == 4 * CHAR_CLK;
  endproperty
  a_hs_width: assert property (p_hs_width)
    else $error("hsync width wrong");
  property p_hb_width;
    $fell(horiz_blank) |-> hb_cnt_reg == 16 * CHAR_CLK;
  endproperty
  a_hb_width: assert property (p_hb_width)
    else $error("hblank width wrong");
  property p_hs_delay;
    $rose(horiz_sync) |-> hb_cnt_reg == 4 * CHAR_CLK;
  endproperty
  a_hs_delay: assert property (p_hs_delay)
    else $error("hsync start wrong");
  property p_line_len;
    horiz_blank && !hb_q_reg && seen_reg |-> line_cnt_reg == 80 * CHAR_CLK;
  endproperty
  a_line_len: assert property (p_line_len)
    else $error("line length wrong");
  property p_ready_sel;
    !ready_n |-> dev_select || $past(dev_select) || $past(dev_select, 2) || $past(dev_select, 3);
  endproperty
  a_ready_sel: assert property (p_ready_sel)
    else $error("ready while not selected");
  property p_push_busy;
    $fell(output_bus_strobe_n) && dev_select && !ready_n |-> ##[1:8] ready_n;
  endproperty
  a_push_busy: assert property (p_push_busy)
    else $error("no busy after byte");
  property p_fill_busy;
    space_force_enable |-> ready_n;
  endproperty
  a_fill_busy: assert property (p_fill_busy)
    else $error("ready during fill");
  // a load pulse comes once per character time, so a fill write follows soon
  property p_fill_we;
    space_force_enable |-> ##[1:204] write_enable;
  endproperty
  a_fill_we: assert property (p_fill_we)
    else $error("no write during fill");
endmodule
bind crtc_top crtc_top_checker #(.ALARM_LEN(ALARM_LEN)) u_crtc_top_checker (
  .clk_sys(clk_sys), .srst(srst), .dev_select(dev_select), .output_bus(output_bus),
  .output_bus_strobe_n(output_bus_strobe_n), .ready_n(ready_n), .write_enable(write_enable),
  .space_force_enable(space_force_enable), .horiz_blank(horiz_blank),
  .horiz_sync(horiz_sync), .vert_blank(vert_blank), .vert_sync(vert_sync),
  .video_on(video_on), .video_char(video_char), .cursor_on(cursor_on),
  .alarm_pulse(alarm_pulse)
);
